// ---- verilog/gdmr_pkg.sv ----
package gdmr_pkg;

  // ****************************************************************
  // Command bytes received from the host.
  // ****************************************************************
  localparam logic [7:0] CMD_SET_CFG0 = 8'h81;
  localparam logic [7:0] CMD_GET_CFG0 = 8'h82;
  localparam logic [7:0] CMD_STATUS0 = 8'h85;
  localparam logic [7:0] CMD_STATUS1 = 8'h86;

  // ****************************************************************
  // First bytes of device replies and unsolicited reports.
  // ****************************************************************
  localparam logic [7:0] RSP_SET_CFG0_NAK = 8'h01;
  localparam logic [7:0] RSP_SET_CFG0_ACK = 8'h41;
  localparam logic [7:0] RSP_GET_CFG0_NAK = 8'h02;
  localparam logic [7:0] RSP_GET_CFG0_ACK = 8'h42;
  localparam logic [7:0] RSP_STATUS0_NAK = 8'h05;
  localparam logic [7:0] RSP_STATUS0_ACK = 8'h45;
  localparam logic [7:0] RSP_STATUS1_NAK = 8'h06;
  localparam logic [7:0] RSP_STATUS1_ACK = 8'h46;
  localparam logic [7:0] RPT_STATUS0 = 8'h85;
  localparam logic [7:0] RPT_STATUS1 = 8'h86;
  localparam logic [7:0] RSP_UNKNOWN_NAK = 8'h00;

  // ****************************************************************
  // Field positions and reset values.
  // ****************************************************************
  localparam int unsigned S1_BOR_BIT = 4;
  localparam logic [7:0] S0_RESERVED_MASK = 8'h08;
  localparam logic [7:0] S1_USED_MASK = 8'h0f;
  localparam logic [7:0] CFG0_WRITABLE_MASK = 8'h4f;
  localparam logic [7:0] CFG0_RESET = 8'h00;
  localparam logic [7:0] S1_RESET = 8'h10;
  localparam int unsigned CFG0_PULLUP_BIT = 6;
  localparam int unsigned CFG0_UNDERVOLTAGE_LOCKOUT_BIT = 3;
  localparam int unsigned CFG0_OCP_DIS_BIT = 2;

  // Two-byte message as it leaves the device.
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] payload;
  } gdmr_msg_type;

  typedef enum logic [1:0] {
    GDMR_IDLE = 2'b00,
    GDMR_WAIT_DATA = 2'b01,
    GDMR_SEND_CODE = 2'b10,
    GDMR_SEND_DATA = 2'b11
  } gdmr_state_type;

endpackage

// ---- verilog/gdmr_responder.sv ----
`timescale 1ns/1ps
module gdmr_responder
  import gdmr_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Bytes received from the host message link.
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_error,
  // Bytes sent to the host message link.
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // Fault levels from the analog monitors.
  input wire logic [7:0] fault_primary_in,
  input wire logic [3:0] fault_secondary_in,
  // Configuration outputs to the analog blocks.
  output logic pullup_disconnect,
  output logic undervoltage_lockout_disable,
  output logic ocp_detect_disable,
  output logic [1:0] ocp_threshold_sel
);

  // ****************************************************************
  // Storage.
  // ****************************************************************
  gdmr_state_type state_q;
  gdmr_msg_type msg_q;
  logic [7:0] fault_flags_primary_q;
  logic [7:0] fault_flags_secondary_q;
  logic [7:0] protection_config_q;
  logic [7:0] prev_primary_q;
  logic [3:0] prev_secondary_q;
  logic report0_pend_q;
  logic report1_pend_q;
  logic tx_valid_q;
  logic [7:0] tx_data_q;

  logic [7:0] s0_live;
  logic [7:0] s1_live;
  logic rx_take;
  logic clr_s0;
  logic clr_s1;
  logic cfg_accept;
  logic send_rpt0;
  logic send_rpt1;
  logic byte_sent;

  // Reserved status-0 bit forced low; status-1 keeps only used bits.
  assign s0_live = fault_primary_in & ~S0_RESERVED_MASK;
  assign s1_live = {4'h0, fault_secondary_in};
  assign rx_take = rx_valid && (state_q == GDMR_IDLE ||
                                state_q == GDMR_WAIT_DATA);
  assign byte_sent = tx_valid_q && tx_ready;
  assign send_rpt0 = state_q == GDMR_IDLE && !rx_valid && report0_pend_q;
  assign send_rpt1 = state_q == GDMR_IDLE && !rx_valid &&
                     !report0_pend_q && report1_pend_q;
  // Only a clean, reserved-clear data byte may change the config.
  assign cfg_accept = state_q == GDMR_WAIT_DATA && rx_valid &&
                      !rx_error &&
                      (rx_data & ~CFG0_WRITABLE_MASK) == 8'h00;
  // Flags clear once their contents have been handed out.
  assign clr_s0 = state_q == GDMR_SEND_DATA && byte_sent &&
                  (msg_q.code == RSP_STATUS0_ACK ||
                   msg_q.code == RPT_STATUS0);
  assign clr_s1 = state_q == GDMR_SEND_DATA && byte_sent &&
                  (msg_q.code == RSP_STATUS1_ACK ||
                   msg_q.code == RPT_STATUS1);

  // ****************************************************************
  // Message sequencer.
  // ****************************************************************

  // Host messages take priority over unprompted reports.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= GDMR_IDLE;
      msg_q <= '0;
    end else begin
      case (state_q)
        GDMR_IDLE: begin
          if (rx_valid) begin
            state_q <= GDMR_SEND_CODE;
            if (rx_error) begin
              msg_q <= {RSP_UNKNOWN_NAK, 8'h00};
            end else if (rx_data == CMD_STATUS0) begin
              msg_q <= {RSP_STATUS0_ACK, fault_flags_primary_q};
            end else if (rx_data == CMD_STATUS1) begin
              msg_q <= {RSP_STATUS1_ACK, fault_flags_secondary_q};
            end else if (rx_data == CMD_GET_CFG0) begin
              msg_q <= {RSP_GET_CFG0_ACK, protection_config_q};
            end else if (rx_data == CMD_SET_CFG0) begin
              state_q <= GDMR_WAIT_DATA;
            end else begin
              msg_q <= {RSP_UNKNOWN_NAK, 8'h00};
            end
          end else if (send_rpt0) begin
            state_q <= GDMR_SEND_CODE;
            msg_q <= {RPT_STATUS0, fault_flags_primary_q};
          end else if (send_rpt1) begin
            state_q <= GDMR_SEND_CODE;
            msg_q <= {RPT_STATUS1, fault_flags_secondary_q};
          end
        end
        GDMR_WAIT_DATA: begin
          if (rx_valid) begin
            state_q <= GDMR_SEND_CODE;
            if (cfg_accept) begin
              msg_q <= {RSP_SET_CFG0_ACK, rx_data};
            end else begin
              msg_q <= {RSP_SET_CFG0_NAK, protection_config_q};
            end
          end
        end
        GDMR_SEND_CODE: begin
          if (byte_sent) begin
            state_q <= GDMR_SEND_DATA;
          end
        end
        GDMR_SEND_DATA: begin
          if (byte_sent) begin
            state_q <= GDMR_IDLE;
          end
        end
        default: begin
          state_q <= GDMR_IDLE;
        end
      endcase
    end
  end

  // Transmit byte holds until the link takes it.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
    end else if (tx_valid_q && !tx_ready) begin
      tx_valid_q <= 1'b1;
    end else if (state_q == GDMR_SEND_CODE && !tx_valid_q) begin
      tx_valid_q <= 1'b1;
      tx_data_q <= msg_q.code;
    end else if (state_q == GDMR_SEND_CODE && byte_sent) begin
      tx_valid_q <= 1'b1;
      tx_data_q <= msg_q.payload;
    end else begin
      tx_valid_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Fault flags and unprompted report requests.
  // ****************************************************************

  // Sticky flags; a new fault in the clearing cycle is kept.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fault_flags_primary_q <= 8'h00;
    end else if (clr_s0) begin
      // Faults raised after the payload was captured survive the clear.
      fault_flags_primary_q <= s0_live |
        (fault_flags_primary_q & ~msg_q.payload);
    end else begin
      fault_flags_primary_q <= fault_flags_primary_q | s0_live;
    end
  end

  // The brown-out bit starts set and drops only on an accepted write.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fault_flags_secondary_q <= S1_RESET;
    end else begin
      if (clr_s1) begin
        fault_flags_secondary_q[3:0] <= s1_live[3:0] |
          (fault_flags_secondary_q[3:0] & ~msg_q.payload[3:0]);
      end else begin
        fault_flags_secondary_q[3:0] <=
          fault_flags_secondary_q[3:0] | s1_live[3:0];
      end
      if (cfg_accept) begin
        fault_flags_secondary_q[S1_BOR_BIT] <= 1'b0;
      end
      fault_flags_secondary_q[7:5] <= 3'b000;
    end
  end

  // A rising fault queues a report; it wins over a start in the same cycle.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prev_primary_q <= 8'h00;
      prev_secondary_q <= 4'h0;
      report0_pend_q <= 1'b0;
      report1_pend_q <= 1'b0;
    end else begin
      prev_primary_q <= s0_live;
      prev_secondary_q <= fault_secondary_in;
      if ((s0_live & ~prev_primary_q) != 8'h00) begin
        report0_pend_q <= 1'b1;
      end else if (send_rpt0) begin
        report0_pend_q <= 1'b0;
      end
      if ((fault_secondary_in & ~prev_secondary_q) != 4'h0) begin
        report1_pend_q <= 1'b1;
      end else if (send_rpt1) begin
        report1_pend_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Configuration-0 storage and its outputs.
  // ****************************************************************

  // Refused writes leave the stored value alone.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      protection_config_q <= CFG0_RESET;
    end else if (cfg_accept) begin
      protection_config_q <= rx_data;
    end
  end

  // Registered copies so that every output comes from a flip-flop.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pullup_disconnect <= 1'b0;
      undervoltage_lockout_disable <= 1'b0;
      ocp_detect_disable <= 1'b0;
      ocp_threshold_sel <= 2'b00;
    end else begin
      pullup_disconnect <= protection_config_q[CFG0_PULLUP_BIT];
      undervoltage_lockout_disable <=
        protection_config_q[CFG0_UNDERVOLTAGE_LOCKOUT_BIT];
      ocp_detect_disable <= protection_config_q[CFG0_OCP_DIS_BIT];
      ocp_threshold_sel <= protection_config_q[1:0];
    end
  end

  assign tx_valid = tx_valid_q;
  assign tx_data = tx_data_q;

endmodule

// ---- tb/gdmr_monitor.sv ----
`timescale 1ns/1ps
module gdmr_monitor (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Link towards the host.
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  // Configuration outputs.
  input wire logic pullup_disconnect,
  input wire logic undervoltage_lockout_disable,
  input wire logic ocp_detect_disable,
  input wire logic [1:0] ocp_threshold_sel
);
  // Set while the byte on offer is a payload; tracking it avoids
  // mistaking a payload that looks like a code for a new message.
  logic sec_q;
  logic [7:0] cfg;
  wire take = tx_valid && tx_ready;
  assign cfg = {1'b0, pullup_disconnect, 2'b00,
    undervoltage_lockout_disable, ocp_detect_disable, ocp_threshold_sel};
  always_ff @(posedge clk) begin
    if (!reset_n)
      sec_q <= 1'b0;
    else if (take)
      sec_q <= !sec_q;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_hold; tx_valid && !tx_ready
    |=> tx_valid && $stable(tx_data); endproperty
  a_hold: assert property (p_hold) else $error("byte dropped");
  property p_code; tx_valid && !sec_q |-> tx_data inside {8'h00,
    8'h01, 8'h41, 8'h42, 8'h45, 8'h46, 8'h85, 8'h86}; endproperty
  a_code: assert property (p_code) else $error("bad code");
  property p_next; take && !sec_q |=> tx_valid; endproperty
  a_next: assert property (p_next) else $error("no payload");
  property p_drop; take && sec_q |=> !tx_valid; endproperty
  a_drop: assert property (p_drop) else $error("extra byte");
  property p_cfgpay; take && !sec_q && tx_data inside {8'h01, 8'h41,
    8'h42} |=> tx_data == cfg; endproperty
  a_cfgpay: assert property (p_cfgpay) else $error("cfg payload");
  property p_s0; take && !sec_q && tx_data inside {8'h45, 8'h85}
    |=> !tx_data[3]; endproperty
  a_s0: assert property (p_s0) else $error("reserved bit set");
  property p_s1; take && !sec_q && tx_data inside {8'h46, 8'h86}
    |=> tx_data[7:5] == 3'b000; endproperty
  a_s1: assert property (p_s1) else $error("unused bits set");
  property p_start; $rose(tx_valid) |-> !sec_q; endproperty
  a_start: assert property (p_start) else $error("bad start");
  c_ack: cover property (take && !sec_q && tx_data == 8'h41);
  c_rpt: cover property (take && !sec_q && tx_data == 8'h85);
  c_stall: cover property (tx_valid && !tx_ready);
endmodule

// ---- tb/gdmr_host.sv ----
`timescale 1ns/1ps
module gdmr_host (
  // Clock.
  input wire logic clk,
  // Bytes towards the device.
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_error,
  // Bytes from the device.
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // Pace set by the bench.
  input wire logic stall
);
  // Bytes taken from the device, oldest first.
  logic [7:0] got[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_error = 1'b0;
  end
  assign tx_ready = !stall;
  // Take every byte the device offers while ready.
  always @(posedge clk) begin
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
  end
  // One byte pulse; the idle line shows the inverse, never stale data.
  task automatic put(input logic [7:0] b, input logic e);
    @(posedge clk);
    #1;
    rx_valid = 1'b1;
    rx_data = b;
    rx_error = e;
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
    rx_data = ~b;
    rx_error = 1'b0;
  endtask
endmodule

// ---- tb/gdmr_responder_tb.sv ----
`timescale 1ns/1ps
module gdmr_responder_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] fault_primary_in = 8'h00;
  logic [3:0] fault_secondary_in = 4'h0;
  logic stall = 1'b0;
  logic rx_valid, rx_error, tx_valid, tx_ready;
  logic [7:0] rx_data, tx_data;
  logic pullup_disconnect, undervoltage_lockout_disable;
  logic ocp_detect_disable;
  logic [1:0] ocp_threshold_sel;
  int n_errors = 0;
  int total_checks = 0;
  // Bench copies of configuration and both fault bytes.
  logic [7:0] cfg = 8'h00;
  logic [7:0] s0 = 8'h00;
  logic [7:0] s1 = 8'h10;
  logic [31:0] lfsr = 32'h6a2eaf73;
  wire [7:0] cfg_out = {1'b0, pullup_disconnect, 2'b00,
    undervoltage_lockout_disable, ocp_detect_disable, ocp_threshold_sel};
  always #2.5 clk = ~clk;
  gdmr_responder dut (.clk, .reset_n, .rx_valid, .rx_data, .rx_error,
    .tx_valid, .tx_data, .tx_ready, .fault_primary_in,
    .fault_secondary_in, .pullup_disconnect,
    .undervoltage_lockout_disable, .ocp_detect_disable,
    .ocp_threshold_sel);
  gdmr_host host (.clk, .rx_valid, .rx_data, .rx_error, .tx_valid,
    .tx_data, .tx_ready, .stall);
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Random stalls make the device hold its bytes now and then.
  always @(posedge clk) begin
    #1;
    lfsr = nxt(lfsr);
    stall = lfsr[4] & lfsr[9];
  end
  task automatic chk(input string what, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Wait, bounded, for a whole two-byte message and compare it.
  task automatic expect2(input logic [7:0] ec, ep);
    int i;
    for (i = 0; i < 200 && host.got.size() < 2; i++) begin
      @(posedge clk);
      #1;
    end
    if (host.got.size() < 2) begin
      n_errors++;
      conclude();
    end else begin
      chk("code", host.got.pop_front(), ec);
      chk("payload", host.got.pop_front(), ep);
    end
  endtask
  // Write then read back; bits 7, 5 and 4 or a bad byte are refused.
  task automatic wcfg(input logic [7:0] v, input logic e);
    host.put(8'h81, 1'b0);
    host.put(v, e);
    if (e || (v & 8'hb0) != 8'h00) begin
      expect2(8'h01, cfg);
    end else begin
      cfg = v;
      s1[4] = 1'b0;
      expect2(8'h41, cfg);
    end
    chk("cfg out", cfg_out, cfg);
    host.put(8'h82, 1'b0);
    expect2(8'h42, cfg);
  endtask
  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clk);
    #1;
    reset_n = 1'b1;
    chk("cfg reset", cfg_out, 8'h00);
    host.put(8'h86, 1'b0);
    expect2(8'h46, s1);
    host.put(8'h85, 1'b0);
    expect2(8'h45, s0);
    for (int i = 0; i < 4; i++)
      wcfg({1'b0, lfsr[6], 2'b00, lfsr[3:2], i[1:0]}, 1'b0);
    wcfg(8'h4f, 1'b0);
    wcfg(8'h80 | lfsr[7:0], 1'b0);
    wcfg(8'h10, 1'b0);
    wcfg(8'h00, 1'b1);
    host.put(8'h83, 1'b0);
    expect2(8'h00, 8'h00);
    host.put(8'h85, 1'b1);
    expect2(8'h00, 8'h00);
    // Reserved bit 3 is raised on purpose; the device must mask it.
    fault_primary_in = lfsr[7:0] | 8'h09;
    s0 = fault_primary_in & 8'hf7;
    expect2(8'h85, s0);
    fault_primary_in = 8'h00;
    host.put(8'h85, 1'b0);
    expect2(8'h45, s0);
    host.put(8'h85, 1'b0);
    expect2(8'h45, 8'h00);
    fault_secondary_in = lfsr[3:0] | 4'h1;
    expect2(8'h86, {3'b000, s1[4], fault_secondary_in});
    // A reset in mid-run must bring back the start-up values.
    fault_secondary_in = 4'h0;
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1'b1;
    cfg = 8'h00;
    s1 = 8'h10;
    chk("cfg rereset", cfg_out, cfg);
    host.put(8'h86, 1'b0);
    expect2(8'h46, s1);
    conclude();
  end
endmodule
bind gdmr_responder gdmr_monitor mon (.clk, .reset_n, .tx_valid,
  .tx_data, .tx_ready, .pullup_disconnect,
  .undervoltage_lockout_disable, .ocp_detect_disable,
  .ocp_threshold_sel);
